// ---- core/pgsc_pkg.sv ----
// Package for the power-good, sync and combined status command block.
// Assumes one command at a time from a PMBus transport on clk_sys.
package pgsc_pkg;

  // ----------------------------------------------------------------
  // Command codes and selections
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_TELEMETRY_SNAPSHOT = 8'hDA;
  localparam logic [7:0] CMD_FAULT_SUMMARY      = 8'hDB;
  localparam logic [7:0] CMD_PHASE_FAULT_MAP    = 8'hDC;
  localparam logic [7:0] CMD_PG_TIMING_MASK     = 8'hE3;
  localparam logic [7:0] CMD_SYNC_PIN_SETUP     = 8'hE4;
  localparam logic [7:0] PHASE_ALL              = 8'hFF;
  localparam logic [7:0] PHASE_ALL_ALT          = 8'h80;

  // ----------------------------------------------------------------
  // Field positions, reset values, counter widths and timing constants
  // ----------------------------------------------------------------
  localparam int          PG_LOW_CODE_LSB   = 12;
  localparam int          PG_REL_CODE_LSB   = 8;
  localparam int          SYNC_DIR_LSB      = 6;
  localparam int          SYNC_EDGE_BIT     = 5;
  localparam logic [4:0]  SYNC_FIXED_LOW    = 5'h10;
  localparam logic [15:0] PG_TIMING_RESET   = 16'h0000;
  localparam logic [7:0]  SYNC_SETUP_RESET  = 8'h10;
  localparam int          PG_CNT_W          = 17;
  localparam int          SYNC_CNT_W        = 16;
  localparam int          CLK_SYS_KHZ       = 200000;
  localparam int          SW_FREQ_KHZ_DFLT  = 500;
  localparam int          SYNC_IN_PCT       = 75;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SYNC_DISABLED = 2'h0, SYNC_OUT = 2'h1, SYNC_IN = 2'h2, SYNC_AUTO = 2'h3
  } pgsc_sync_dir_t;

  typedef enum logic [2:0] {
    ROLE_OFF = 3'h1, ROLE_OUT = 3'h2, ROLE_IN = 3'h4
  } pgsc_role_t;

  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] temp;
    logic [15:0] iout;
    logic [15:0] vout;
    logic [15:0] status_word;
  } pgsc_telem_t;

  typedef struct packed {
    logic [7:0] mfr;
    logic [7:0] other;
    logic [7:0] cml;
    logic [7:0] temp;
    logic [7:0] input_v;
    logic [7:0] iout;
    logic [7:0] vout;
  } pgsc_status_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } pgsc_cmd_t;

  typedef struct packed {
    logic         valid;
    logic         hit;
    logic         ivc;
    logic         ivd;
    logic [111:0] data;
  } pgsc_rsp_t;

endpackage : pgsc_pkg

// ---- core/pgsc_cmds.sv ----
// Power-good timing, sync pin setup, phase fault map and combined reads.
// Assumes commands and status inputs on clk_sys, converter events on
// clk_pwm (the PWM clock, one edge per PWM period).
module pgsc_cmds
  import pgsc_pkg::*;
#(
  parameter int          SW_FREQ_KHZ = pgsc_pkg::SW_FREQ_KHZ_DFLT,
  parameter logic [15:0] PG_RESET    = pgsc_pkg::PG_TIMING_RESET,
  parameter logic [7:0]  SYNC_RESET  = pgsc_pkg::SYNC_SETUP_RESET
) (
  // System clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // PWM clock
  input  wire logic               clk_pwm,
  // Command port from the transport
  input  wire pgsc_pkg::pgsc_cmd_t cmd,
  output pgsc_pkg::pgsc_rsp_t     rsp,
  output logic                    cml_ivc_set,
  output logic                    cml_ivd_set,
  // Status sources on clk_sys
  input  wire pgsc_pkg::pgsc_telem_t  telem,
  input  wire pgsc_pkg::pgsc_status_t status,
  input  wire logic [7:0]         phase_sel,
  input  wire logic [3:0]         phase_used,
  input  wire logic [3:0]         phase_fault_evt,
  input  wire logic [15:0]        sel_phase_faults,
  input  wire logic               conv_en,
  input  wire logic               sync_fault,
  // Converter state on clk_pwm
  input  wire logic [7:0]         pg_events,
  input  wire logic [7:0]         pg_continue,
  input  wire logic               in_ton_delay,
  input  wire logic               in_ton_rise,
  input  wire logic               in_toff_fall,
  input  wire logic               in_fault_off,
  // Pins
  input  wire logic               sync_pin_in,
  output logic                    sync_pin_out,
  output logic                    sync_pin_oe,
  output logic                    osc_slow,
  output logic                    power_good_output
);
  import pgsc_pkg::*;

  localparam int SW_PERIOD_CYC = CLK_SYS_KHZ / SW_FREQ_KHZ;
  localparam int SLOW_LIMIT_I  = (SW_PERIOD_CYC * 100 + SYNC_IN_PCT - 1) / SYNC_IN_PCT;
  localparam logic [SYNC_CNT_W-1:0] SLOW_LIMIT = SYNC_CNT_W'(SLOW_LIMIT_I);

  function automatic logic [PG_CNT_W-1:0] pg_delay(input logic [3:0] code);
    pg_delay = (code == 4'h0) ? PG_CNT_W'(1) : (PG_CNT_W'(1) << code) + PG_CNT_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // System domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  pin_meta;
    logic                  pin_sync;
    logic                  pin_prev;
    logic [SYNC_CNT_W-1:0] edge_age;
    logic [SYNC_CNT_W-1:0] last_period;
    logic                  conv_prev;
    logic [15:0]           pg_cfg;
    logic                  cfg_tgl;
    logic [7:0]            sync_cfg;
    pgsc_role_t            role;
    logic                  slow;
    logic                  oe;
    logic [3:0]            map;
    pgsc_rsp_t             rsp;
    logic                  ivc;
    logic                  ivd;
  } pgsc_sys_t;

  pgsc_sys_t r;
  pgsc_sys_t next_r;
  logic      toggling;
  logic      rd;
  logic      wr;

  always_comb begin
    logic           sel_edge;
    pgsc_sync_dir_t new_dir;
    next_r   = r;
    sel_edge = 1'b0;
    new_dir  = SYNC_DISABLED;
    rd       = cmd.valid && !cmd.write;
    wr       = cmd.valid && cmd.write;
    next_r.pin_meta  = sync_pin_in;
    next_r.pin_sync  = r.pin_meta;
    next_r.pin_prev  = r.pin_sync;
    next_r.conv_prev = conv_en;
    // Selected edge of the sync pin for rate detection.
    if (r.sync_cfg[SYNC_EDGE_BIT]) begin
      sel_edge = r.pin_sync && !r.pin_prev;
    end else begin
      sel_edge = !r.pin_sync && r.pin_prev;
    end
    if (sel_edge) begin
      next_r.last_period = r.edge_age;
      next_r.edge_age    = '0;
    end else if (r.edge_age < SLOW_LIMIT) begin
      next_r.edge_age = r.edge_age + SYNC_CNT_W'(1);
    end
    toggling = (r.edge_age < SLOW_LIMIT) && (r.last_period < SLOW_LIMIT);
    // Sync role follows the direction field, auto resolves at enable.
    case (pgsc_sync_dir_t'(r.sync_cfg[SYNC_DIR_LSB +: 2]))
      SYNC_OUT:      next_r.role = ROLE_OUT;
      SYNC_IN:       next_r.role = ROLE_IN;
      SYNC_AUTO: begin
        if (conv_en && !r.conv_prev) begin
          next_r.role = (r.pin_sync || toggling) ? ROLE_IN : ROLE_OUT;
        end
      end
      default:       next_r.role = ROLE_OFF;
    endcase
    next_r.oe = (r.role == ROLE_OUT) && conv_en;
    if (!conv_en) begin
      next_r.slow = 1'b0;
    end
    // Phase fault flags are sticky; a new fault wins over a clear.
    next_r.map = r.map;
    if (wr && cmd.code == CMD_PHASE_FAULT_MAP) begin
      next_r.map = r.map & ~cmd.wdata[3:0];
    end
    next_r.map = (next_r.map | phase_fault_evt) & phase_used;
    // Command decode; one answer the cycle after each command.
    next_r.rsp       = '0;
    next_r.ivc       = 1'b0;
    next_r.ivd       = 1'b0;
    next_r.rsp.valid = cmd.valid;
    case (cmd.code)
      CMD_TELEMETRY_SNAPSHOT: begin
        next_r.rsp.hit = 1'b1;
        if (wr) begin
          next_r.ivc = 1'b1;
        end else begin
          next_r.rsp.data = {32'h0000_0000, telem};
        end
      end
      CMD_FAULT_SUMMARY: begin
        next_r.rsp.hit = 1'b1;
        if (wr) begin
          next_r.ivc = 1'b1;
        end else begin
          next_r.rsp.data = {56'h00_0000_0000_0000, status};
        end
      end
      CMD_PHASE_FAULT_MAP: begin
        next_r.rsp.hit = 1'b1;
        if (phase_sel == PHASE_ALL || phase_sel == PHASE_ALL_ALT) begin
          next_r.rsp.data = {108'h0, r.map & phase_used};
        end else begin
          next_r.rsp.data = {96'h0, sel_phase_faults};
        end
      end
      CMD_PG_TIMING_MASK: begin
        next_r.rsp.hit  = 1'b1;
        next_r.rsp.data = {96'h0, r.pg_cfg};
        if (wr && conv_en) begin
          next_r.ivd = 1'b1;
        end else if (wr) begin
          next_r.pg_cfg  = cmd.wdata;
          next_r.cfg_tgl = !r.cfg_tgl;
        end
      end
      CMD_SYNC_PIN_SETUP: begin
        next_r.rsp.hit  = 1'b1;
        next_r.rsp.data = {104'h0, r.sync_cfg};
        if (wr && cmd.wdata[4:0] != SYNC_FIXED_LOW) begin
          next_r.ivd = 1'b1;
        end else if (wr) begin
          next_r.sync_cfg = cmd.wdata[7:0];
          new_dir = pgsc_sync_dir_t'(cmd.wdata[SYNC_DIR_LSB +: 2]);
          if (r.role == ROLE_IN && new_dir == SYNC_OUT && conv_en && sync_fault) begin
            next_r.slow = 1'b1;
          end
        end
      end
      default: next_r.rsp.hit = 1'b0;
    endcase
    next_r.rsp.ivc = next_r.ivc;
    next_r.rsp.ivd = next_r.ivd;
    if (!cmd.valid) begin
      next_r.rsp = '0;
      next_r.ivc = 1'b0;
      next_r.ivd = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r          <= '0;
      r.pg_cfg   <= PG_RESET;
      r.sync_cfg <= SYNC_RESET;
      r.role     <= ROLE_OFF;
    end else begin
      r <= next_r;
    end
  end

  assign rsp         = r.rsp;
  assign cml_ivc_set = r.ivc;
  assign cml_ivd_set = r.ivd;
  assign sync_pin_oe = r.oe;
  assign osc_slow    = r.slow;

  // ----------------------------------------------------------------
  // PWM domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          rsync;
    logic                en_meta;
    logic                en_sync;
    logic                tgl_meta;
    logic                tgl_sync;
    logic                tgl_prev;
    logic [15:0]         cfg;
    logic [PG_CNT_W-1:0] off_cnt;
    logic [PG_CNT_W-1:0] on_cnt;
    logic                pg;
    logic                drv;
  } pgsc_pwm_t;

  pgsc_pwm_t p;
  pgsc_pwm_t next_p;
  logic      qual;
  logic      hold;
  logic      bad;

  always_comb begin
    next_p          = p;
    next_p.rsync    = {p.rsync[0], rst};
    next_p.en_meta  = conv_en;
    next_p.en_sync  = p.en_meta;
    next_p.tgl_meta = r.cfg_tgl;
    next_p.tgl_sync = p.tgl_meta;
    next_p.tgl_prev = p.tgl_sync;
    next_p.drv      = !p.drv;
    // Copied on each toggle and all the time while conversion is off, so two
    // writes closer than one PWM clock still land; power good is held then.
    if (!p.en_sync || p.tgl_sync != p.tgl_prev) begin
      next_p.cfg = r.pg_cfg;
    end
    qual = |(pg_events & ~p.cfg[7:0] & ~pg_continue);
    hold = !p.en_sync || in_ton_delay || in_ton_rise || in_toff_fall || in_fault_off;
    bad  = qual || hold;
    // Independent delay timers, reloaded while their condition is absent.
    if (!qual) begin
      next_p.off_cnt = pg_delay(p.cfg[PG_LOW_CODE_LSB +: 4]);
    end else if (p.off_cnt > PG_CNT_W'(1)) begin
      next_p.off_cnt = p.off_cnt - PG_CNT_W'(1);
    end
    if (bad) begin
      next_p.on_cnt = pg_delay(p.cfg[PG_REL_CODE_LSB +: 4]);
    end else if (p.on_cnt > PG_CNT_W'(1)) begin
      next_p.on_cnt = p.on_cnt - PG_CNT_W'(1);
    end
    if (hold) begin
      next_p.pg = 1'b0;
    end else if (p.pg && qual && p.off_cnt == PG_CNT_W'(1)) begin
      next_p.pg = 1'b0;
    end else if (!p.pg && !bad && p.on_cnt == PG_CNT_W'(1)) begin
      next_p.pg = 1'b1;
    end
  end

  always_ff @(posedge clk_pwm) begin
    if (p.rsync[1]) begin
      p       <= '0;
      p.rsync <= next_p.rsync;
      p.cfg   <= PG_RESET;
    end else begin
      p <= next_p;
    end
  end

  assign power_good_output = p.pg;
  assign sync_pin_out      = p.drv;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SNAP_TOP_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    (rd && cmd.code == CMD_TELEMETRY_SNAPSHOT) |=> (rsp.valid && rsp.data[111:80] == 32'h0))
    else $error("snapshot top words not zero");
  AST_SNAP_FIELDS: assert property (@(posedge clk_sys) disable iff (rst)
    (rd && cmd.code == CMD_TELEMETRY_SNAPSHOT) |=> (rsp.data[79:64] == $past(telem.vin)
      && rsp.data[15:0] == $past(telem.status_word)))
    else $error("snapshot field order wrong");
  AST_RO_WRITE_IVC: assert property (@(posedge clk_sys) disable iff (rst)
    (wr && (cmd.code == CMD_TELEMETRY_SNAPSHOT || cmd.code == CMD_FAULT_SUMMARY))
      |=> (cml_ivc_set && rsp.ivc && !cml_ivd_set))
    else $error("read-only write not flagged");
  AST_STATUS_BLOCK: assert property (@(posedge clk_sys) disable iff (rst)
    (rd && cmd.code == CMD_FAULT_SUMMARY) |=> (rsp.data[55:0] == $past(status)))
    else $error("status block mismatch");
  AST_MAP_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    (rd && cmd.code == CMD_PHASE_FAULT_MAP && phase_sel == PHASE_ALL)
      |=> (rsp.data[15:4] == 12'h0 && (rsp.data[3:0] & ~$past(phase_used)) == 4'h0))
    else $error("unused phase bits set");
  AST_SYNC_BAD_DATA: assert property (@(posedge clk_sys) disable iff (rst)
    (wr && cmd.code == CMD_SYNC_PIN_SETUP && cmd.wdata[4:0] != SYNC_FIXED_LOW)
      |=> (cml_ivd_set && $stable(r.sync_cfg)))
    else $error("invalid sync setup accepted");
  AST_AUTO_PICKS_IN: assert property (@(posedge clk_sys) disable iff (rst)
    (conv_en && !r.conv_prev && r.sync_cfg[7:6] == 2'h3 && r.pin_sync)
      |=> (r.role == ROLE_IN))
    else $error("auto detect missed high pin");
  AST_PG_HOLD_LOW: assert property (@(posedge clk_pwm) disable iff (p.rsync[1])
    hold |=> !power_good_output)
    else $error("power good high while held");
  AST_PG_MASKED: assert property (@(posedge clk_pwm) disable iff (p.rsync[1])
    (!hold && power_good_output && (pg_events & ~p.cfg[7:0] & ~pg_continue) == 8'h00)
      |=> power_good_output)
    else $error("masked event dropped power good");
  AST_PG_REL_CODE1: assert property (@(posedge clk_pwm) disable iff (p.rsync[1])
    (!power_good_output && $past(bad) && !bad && p.cfg[11:8] == 4'h1 && $stable(p.cfg))
      ##1 !bad ##1 !bad |=> power_good_output)
    else $error("release delay not three clocks");
  AST_PG_CONTINUE: assert property (@(posedge clk_pwm) disable iff (p.rsync[1])
    (!hold && power_good_output && pg_events != 8'h00
      && (pg_events & ~pg_continue) == 8'h00)
      |=> power_good_output)
    else $error("continue-response event dropped power good");
  AST_PG_SKIP_DELAY: assert property (@(posedge clk_pwm) disable iff (p.rsync[1])
    (in_toff_fall || in_fault_off) |=> !power_good_output)
    else $error("power good kept high in shutdown");
  AST_PHASE_DETAIL: assert property (@(posedge clk_sys) disable iff (rst)
    (rd && cmd.code == CMD_PHASE_FAULT_MAP
      && phase_sel != PHASE_ALL && phase_sel != PHASE_ALL_ALT)
      |=> (rsp.data[15:0] == $past(sel_phase_faults)))
    else $error("selected phase detail mismatch");
  AST_MAP_SET_WINS: assert property (@(posedge clk_sys) disable iff (rst)
    (|(phase_fault_evt & phase_used))
      |=> ((r.map & $past(phase_fault_evt) & $past(phase_used))
        == ($past(phase_fault_evt) & $past(phase_used))))
    else $error("phase fault flag not set");
  AST_SLOW_ON_SWITCH: assert property (@(posedge clk_sys) disable iff (rst)
    (wr && cmd.code == CMD_SYNC_PIN_SETUP && cmd.wdata[4:0] == SYNC_FIXED_LOW
      && cmd.wdata[7:6] == 2'h1 && r.role == ROLE_IN && conv_en && sync_fault)
      |=> osc_slow)
    else $error("oscillator not slowed");
  AST_ROLE_FOLLOWS_DIR: assert property (@(posedge clk_sys) disable iff (rst)
    (r.sync_cfg[7:6] == 2'h1) |=> (r.role == ROLE_OUT))
    else $error("sync role does not follow direction");
  AST_AUTO_PICKS_OUT: assert property (@(posedge clk_sys) disable iff (rst)
    (conv_en && !r.conv_prev && r.sync_cfg[7:6] == 2'h3 && !r.pin_sync && !toggling)
      |=> (r.role == ROLE_OUT))
    else $error("auto detect missed idle low pin");
  AST_SYNC_LOW_FIXED: assert property (@(posedge clk_sys) disable iff (rst)
    (rd && cmd.code == CMD_SYNC_PIN_SETUP) |=> (rsp.data[4:0] == SYNC_FIXED_LOW))
    else $error("sync low bits not fixed");

endmodule : pgsc_cmds

// ---- test/pgsc_host_model.sv ----
// Host-side command source for the power-good and sync command block.
// Assumes one command at a time, launched just after a clk_sys edge.
module pgsc_host_model
  import pgsc_pkg::*;
(
  // Clock
  input  wire logic           clk_sys,
  // Command port
  output pgsc_pkg::pgsc_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial cmd = '0;

  // One-cycle strobe; released lines are inverted so no stale value shows.
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    cmd = '{1'b1, w, c, d};
    @(posedge clk_sys);
    #1;
    cmd = '{1'b0, ~w, ~c, ~d};
  endtask
endmodule // pgsc_host_model

// ---- test/pgsc_tb.sv ----
// Self-checking bench for the power-good, sync and status command block.
// Assumes the host model drives commands; pwm-domain inputs move after clk_pwm.
module pgsc_cmds_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pgsc_pkg::*;

  typedef struct packed {
    logic         rd;
    logic         hit;
    logic         ivc;
    logic         ivd;
    logic [111:0] data;
  } pgsc_exp_t;

  logic        clk_sys = 1'b0, clk_pwm = 1'b0, rst = 1'b1;
  pgsc_cmd_t   cmd;
  pgsc_rsp_t   rsp;
  logic        cml_ivc_set, cml_ivd_set, sync_pin_out, sync_pin_oe, osc_slow;
  logic        power_good_output;
  pgsc_telem_t telem = '0;
  pgsc_status_t status = '0;
  logic [7:0]  phase_sel = PHASE_ALL, pg_events = '0, pg_continue = '0, d;
  logic [3:0]  phase_used = '0, phase_fault_evt = '0;
  logic [15:0] sel_phase_faults = '0;
  logic        conv_en = 1'b0, sync_fault = 1'b0, sync_pin_in = 1'b0;
  logic        in_ton_delay = 1'b0, in_ton_rise = 1'b0, in_toff_fall = 1'b0;
  logic        in_fault_off = 1'b0, pin_was;
  logic [95:0] rv;
  pgsc_exp_t   expq[$];
  pgsc_exp_t   e;
  int          error_cnt = 0, n_compared = 0;

  // ----------------------------------------------------------------
  // Clocks and instances
  // ----------------------------------------------------------------
  initial forever #2.5 clk_sys = ~clk_sys;
  initial begin
    #13;
    forever #32 clk_pwm = ~clk_pwm;
  end

  pgsc_host_model host (.clk_sys(clk_sys), .cmd(cmd));

  pgsc_cmds #(.SW_FREQ_KHZ(5000)) DUT (
    .clk_sys(clk_sys), .rst(rst), .clk_pwm(clk_pwm), .cmd(cmd), .rsp(rsp),
    .cml_ivc_set(cml_ivc_set), .cml_ivd_set(cml_ivd_set), .telem(telem),
    .status(status), .phase_sel(phase_sel), .phase_used(phase_used),
    .phase_fault_evt(phase_fault_evt), .sel_phase_faults(sel_phase_faults),
    .conv_en(conv_en), .sync_fault(sync_fault), .pg_events(pg_events),
    .pg_continue(pg_continue), .in_ton_delay(in_ton_delay),
    .in_ton_rise(in_ton_rise), .in_toff_fall(in_toff_fall),
    .in_fault_off(in_fault_off), .sync_pin_in(sync_pin_in),
    .sync_pin_out(sync_pin_out), .sync_pin_oe(sync_pin_oe),
    .osc_slow(osc_slow), .power_good_output(power_good_output));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] wd,
                      input logic h, input logic ivc, input logic ivd,
                      input logic [111:0] x);
    expq.push_back('{~w, h, ivc, ivd, x});
    host.send(w, c, wd);
  endtask

  task automatic pwm(input int n);
    repeat (n) @(posedge clk_pwm);
    #1;
  endtask

  task automatic end_of_test;
    // An answer that never came leaves its note behind.
    if (expq.size() != 0) error_cnt++;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Response monitor: each answer is matched to the oldest note.
  always @(negedge clk_sys) begin
    if (rsp.valid === 1'b1) begin
      if (expq.size() == 0) begin
        check(128'h1, 128'h0);
      end else begin
        e = expq.pop_front();
        check({rsp.hit, rsp.ivc, rsp.ivd, cml_ivc_set, cml_ivd_set},
              {e.hit, e.ivc, e.ivd, e.ivc, e.ivd});
        if (e.rd) check(rsp.data, e.data);
      end
    end
  end

  initial begin
    #50000;
    error_cnt++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(20));
    repeat (8) @(posedge clk_pwm);
    #1;
    rst = 1'b0;
    xfer(0, CMD_PG_TIMING_MASK, 16'h0000, 1, 0, 0, {96'h0, PG_TIMING_RESET});
    xfer(0, CMD_SYNC_PIN_SETUP, 16'h0000, 1, 0, 0, {104'h0, SYNC_SETUP_RESET});
    rv = {$urandom(), $urandom(), $urandom()};
    telem = rv[79:0];
    status = rv[95:40];
    xfer(0, CMD_TELEMETRY_SNAPSHOT, 16'h0000, 1, 0, 0, {32'h0, telem});
    xfer(0, CMD_FAULT_SUMMARY, 16'h0000, 1, 0, 0, {56'h0, status});
    xfer(1, CMD_FAULT_SUMMARY, 16'hFFFF, 1, 1, 0, '0);
    xfer(1, CMD_TELEMETRY_SNAPSHOT, 16'h0000, 1, 1, 0, '0);
    xfer(0, CMD_FAULT_SUMMARY, 16'h0000, 1, 0, 0, {56'h0, status});
    xfer(0, 8'hD5, 16'h0000, 0, 0, 0, '0);
    // Phase map: bit 2 faults on an unused phase, bit 1 on a used one.
    phase_used = 4'b1011;
    phase_fault_evt = 4'b0110;
    @(posedge clk_sys);
    #1;
    phase_fault_evt = 4'h0;
    xfer(0, CMD_PHASE_FAULT_MAP, 16'h0000, 1, 0, 0, {108'h0, 4'h2});
    phase_sel = PHASE_ALL_ALT;
    xfer(0, CMD_PHASE_FAULT_MAP, 16'h0000, 1, 0, 0, {108'h0, 4'h2});
    phase_sel = 8'h02;
    sel_phase_faults = rv[15:0];
    xfer(0, CMD_PHASE_FAULT_MAP, 16'h0000, 1, 0, 0, {96'h0, rv[15:0]});
    phase_sel = PHASE_ALL;
    xfer(1, CMD_PHASE_FAULT_MAP, 16'h0002, 1, 0, 0, '0);
    xfer(0, CMD_PHASE_FAULT_MAP, 16'h0000, 1, 0, 0, '0);
    // Sync setup: every direction, both edges, fixed low bits.
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], i[0], SYNC_FIXED_LOW};
      xfer(1, CMD_SYNC_PIN_SETUP, {8'h0, d}, 1, 0, 0, '0);
      xfer(0, CMD_SYNC_PIN_SETUP, 16'h0000, 1, 0, 0, {104'h0, d});
    end
    xfer(1, CMD_SYNC_PIN_SETUP, 16'h0091, 1, 0, 1, '0);
    xfer(0, CMD_SYNC_PIN_SETUP, 16'h0000, 1, 0, 0, {104'h0, d});
    // Power good: low delay 9 clocks, release delay 3, out OV fault masked.
    xfer(1, CMD_PG_TIMING_MASK, 16'h3180, 1, 0, 0, '0);
    xfer(0, CMD_PG_TIMING_MASK, 16'h0000, 1, 0, 0, {96'h0, 16'h3180});
    pg_continue = 8'h40;
    pwm(6);
    check(power_good_output, 1'b0);
    in_ton_delay = 1'b1;
    conv_en = 1'b1;
    pwm(12);
    check(power_good_output, 1'b0);
    in_ton_delay = 1'b0;
    pwm(2);
    check(power_good_output, 1'b0);
    pwm(3);
    check(power_good_output, 1'b1);
    pg_events = 8'h01;
    pwm(3);
    pg_events = 8'h00;
    pwm(10);
    check(power_good_output, 1'b1);
    pg_events = 8'h80;
    pwm(15);
    check(power_good_output, 1'b1);
    pg_events = 8'h40;
    pwm(15);
    check(power_good_output, 1'b1);
    pg_events = 8'h08;
    pwm(7);
    check(power_good_output, 1'b1);
    pwm(4);
    check(power_good_output, 1'b0);
    pg_events = 8'h00;
    pwm(12);
    check(power_good_output, 1'b1);
    in_toff_fall = 1'b1;
    pwm(2);
    check(power_good_output, 1'b0);
    in_toff_fall = 1'b0;
    pwm(6);
    check(power_good_output, 1'b1);
    in_fault_off = 1'b1;
    pwm(2);
    check(power_good_output, 1'b0);
    in_fault_off = 1'b0;
    in_ton_rise = 1'b1;
    pwm(6);
    check(power_good_output, 1'b0);
    in_ton_rise = 1'b0;
    xfer(1, CMD_PG_TIMING_MASK, 16'h0000, 1, 0, 1, '0);
    // Auto detect: pin high picks input, pin low and idle picks output.
    conv_en = 1'b0;
    xfer(1, CMD_SYNC_PIN_SETUP, 16'h00D0, 1, 0, 0, '0);
    sync_pin_in = 1'b1;
    pwm(4);
    conv_en = 1'b1;
    pwm(6);
    check(sync_pin_oe, 1'b0);
    conv_en = 1'b0;
    sync_pin_in = 1'b0;
    pwm(4);
    conv_en = 1'b1;
    pwm(6);
    check(sync_pin_oe, 1'b1);
    pin_was = sync_pin_out;
    pwm(1);
    check(sync_pin_out ^ pin_was, 1'b1);
    // Input to output under a sync fault slows the oscillator.
    sync_fault = 1'b1;
    xfer(1, CMD_SYNC_PIN_SETUP, 16'h0090, 1, 0, 0, '0);
    xfer(1, CMD_SYNC_PIN_SETUP, 16'h0050, 1, 0, 0, '0);
    pwm(2);
    check(osc_slow, 1'b1);
    conv_en = 1'b0;
    pwm(2);
    check(osc_slow, 1'b0);
    end_of_test;
  end
endmodule // pgsc_cmds_tb
